// ==== dchp_host_port.v ====
`timescale 1ns/1ps
`include "dchp_regs.vh"
// Summary of operation
// - Select when address bits 7:4 match switch
// - Low address nibble picks one of sixteen
// - Offsets 0-7: buffer, error/precomp, parameters, status/command
// - Offsets 8-A load DMA address; reads unselected
// - Jumper adds two waits on every access
// - All transfers are eight bits wide
// - One vectored interrupt, level chosen by configuration
// - Internal reset follows one chosen bus reset
// - 1K buffer holds one sector of up to 1023 bytes
// - Buffer counter increments per access, clears on command
// - DMA mode masters bus, moves sector unaided
// - Resolve master priority before driving the bus
// - Control bit plus jumper gives four head bits
// - Four syndrome bytes computed as data passes
// - Up to three hard and four floppy units
// - Error register holds diagnostic result after test
// - Diagnostics stop at first failing unit
// - Status error bit clear after diagnostics
// - Diagnostic codes zero pass through five processor
// - Error register bits active high per cause
module dchp_host_port #(
    parameter BUF_DEPTH = `DCHP_BUF_DEPTH,
    parameter BUF_AW    = 10,
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW   = 5
) (
    input  wire               clk,
    input  wire               rst,
    input  wire               busResetA,
    input  wire               busResetB,
    input  wire               resetSelect,
    input  wire [3:0]         baseAddressSwitch,
    input  wire               twoWaitJumper,
    input  wire               headExtendJumper,
    input  wire [2:0]         irqLevelSelect,
    input  wire [7:0]         ioAddr,
    input  wire               ioRead,
    input  wire               ioWrite,
    input  wire [7:0]         dataIn,
    output reg  [7:0]         dataOut,
    output wire               dataOutEn_n,
    output wire               waitReq,
    output wire               ioDone,
    output wire [7:0]         irqOut,
    input  wire               driveIrq,
    input  wire [7:0]         driveStatus,
    input  wire [7:0]         driveError,
    input  wire               driveErrorValid,
    input  wire [7:0]         diagCode,
    input  wire               diagDone,
    output reg                cmdStrobe,
    output reg  [7:0]         cmdCode,
    output wire [3:0]         headSelect,
    output wire [1:0]         hardUnit,
    output wire [1:0]         floppyUnit,
    output wire               unitIsFloppy,
    output reg  [7:0]         precompCyl,
    output reg  [7:0]         sectorCount,
    output reg  [7:0]         sectorNumber,
    output reg  [7:0]         trackLow,
    output reg  [7:0]         trackHigh,
    output reg  [7:0]         sdhReg,
    input  wire               diskWrEn,
    input  wire [BUF_AW-1:0]  diskAddr,
    input  wire [7:0]         diskWrData,
    output reg  [7:0]         diskRdData,
    output reg  [31:0]        eccSyndrome,
    input  wire               busRequestIn_n,
    output wire               busRequestOut_n,
    input  wire               busGrant,
    output reg  [23:0]        dmaAddr,
    output reg  [7:0]         dmaDataOut,
    input  wire [7:0]         dmaDataIn,
    output reg                dmaMemRead,
    output reg                dmaMemWrite,
    input  wire               dmaAck,
    output wire               dmaActive
);
    localparam S_IDLE = 2'd0;
    localparam S_WAIT = 2'd1;
    localparam S_DONE = 2'd2;

    localparam D_IDLE = 2'd0;
    localparam D_ARB  = 2'd1;
    localparam D_MOVE = 2'd2;

    function [9:0] sectorBytes;
        input [1:0] code;
        begin
            case (code)
                2'd0:    sectorBytes = 10'd256;
                2'd1:    sectorBytes = 10'd512;
                2'd2:    sectorBytes = 10'd1023;
                default: sectorBytes = 10'd128;
            endcase
        end
    endfunction

    // The chosen bus reset is folded into the asynchronous reset.
    wire        intRst = rst | (resetSelect ? busResetB : busResetA);

    reg  [7:0]  buffer [0:BUF_DEPTH-1];

    reg  [1:0]  ioState_reg;
    reg  [1:0]  waitCnt_reg;
    reg  [BUF_AW-1:0] bufPtr_reg;
    reg  [7:0]  errorReg_reg;
    reg         diagMode_reg;

    reg  [7:0]  control_reg;
    reg  [1:0]  dmaState_reg;
    reg  [9:0]  dmaLeft_reg;
    reg  [7:0]  rdData;
    reg         readSel;

    // A foreign base leaves every output alone.
    wire        selected = (ioAddr[7:4] == baseAddressSwitch);
    wire [3:0]  offset   = ioAddr[3:0];

    wire        anyCycle = selected && (ioRead || ioWrite);
    wire        needWait = twoWaitJumper;
    // With the jumper, the third edge of the strobe takes it.
    wire        accept   = anyCycle && (ioState_reg == S_IDLE || ioState_reg == S_WAIT) &&
                           (!needWait || (ioState_reg == S_WAIT &&
                                         waitCnt_reg == `DCHP_WAIT_STATES));
    wire        wrAcc    = accept && ioWrite;
    wire        rdAcc    = accept && ioRead;

    assign waitReq = anyCycle && needWait && !accept;
    assign ioDone  = accept;

    // Reads at offsets 8 and up are not decoded, so the bus is left alone.
    always @* begin
        readSel = ioRead && selected && !offset[3];
    end
    assign dataOutEn_n = !readSel;

    // A taken access waits for its strobe to drop.
    always @(posedge clk or posedge intRst) begin
        if (intRst) begin
            ioState_reg <= S_IDLE;
            waitCnt_reg <= 2'd0;
        end else begin
            case (ioState_reg)
                S_IDLE: begin
                    if (anyCycle && needWait && !accept) begin
                        ioState_reg <= S_WAIT;
                        waitCnt_reg <= 2'd1;
                    end else if (accept) begin
                        ioState_reg <= S_DONE;
                    end
                end

                S_WAIT: begin
                    if (accept) begin
                        ioState_reg <= S_DONE;
                    end else begin
                        waitCnt_reg <= waitCnt_reg + 2'd1;
                    end
                end

                S_DONE: begin
                    if (!anyCycle) begin
                        ioState_reg <= S_IDLE;
                        waitCnt_reg <= 2'd0;
                    end
                end
                default: ioState_reg <= S_IDLE;
            endcase
        end
    end

    wire        dmaBufRd = (dmaState_reg == D_MOVE) && control_reg[`DCHP_CTL_DMADIR];
    wire        fifoInReady;
    wire        fifoOutValid;
    wire [7:0]  fifoOutData;
    wire        fifoOutReady = (dmaState_reg == D_MOVE) && dmaAck && dmaMemWrite;
    wire        fifoPush = dmaBufRd && fifoInReady && dmaLeft_reg != 10'd0;

    wire        hostBufAcc = (rdAcc || wrAcc) && offset == `DCHP_OFS_BUFFER;
    wire        dmaBufWr = (dmaState_reg == D_MOVE) && dmaMemRead && dmaAck;

    // Disk side has priority on the buffer; the host side waits by sequencing.
    always @(posedge clk) begin
        if (diskWrEn) begin
            buffer[diskAddr] <= diskWrData;
        end else if (wrAcc && offset == `DCHP_OFS_BUFFER) begin
            buffer[bufPtr_reg] <= dataIn;
        end else if (dmaBufWr) begin
            buffer[bufPtr_reg] <= dmaDataIn;
        end
        diskRdData <= buffer[diskAddr];
    end

    dchp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) uFifo (
        .clk      (clk),
        .rst      (intRst),
        .inData   (buffer[bufPtr_reg]),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady)
    );

    // Bit 0 is masked so a finished self-test never reads as failed.
    always @* begin
        case (offset)
            `DCHP_OFS_BUFFER:  rdData = buffer[bufPtr_reg];
            `DCHP_OFS_ERROR:   rdData = errorReg_reg;
            `DCHP_OFS_COUNT:   rdData = sectorCount;
            `DCHP_OFS_SECTOR:  rdData = sectorNumber;
            `DCHP_OFS_TRKLO:   rdData = trackLow;
            `DCHP_OFS_TRKHI:   rdData = trackHigh;
            `DCHP_OFS_SDH:     rdData = sdhReg;
            `DCHP_OFS_CMDSTAT: rdData = diagMode_reg ?
                                   (driveStatus & 8'hFE) : driveStatus;
            default:           rdData = 8'h00;
        endcase
    end

    // Host writes win over DMA stepping; load the address while idle.
    always @(posedge clk or posedge intRst) begin
        if (intRst) begin
            dataOut      <= 8'h00;
            bufPtr_reg   <= {BUF_AW{1'b0}};
            errorReg_reg <= `DCHP_DIAG_PASS;
            diagMode_reg <= 1'b1;
            control_reg  <= 8'h00;
            precompCyl   <= 8'h00;
            sectorCount  <= 8'h00;
            sectorNumber <= 8'h00;
            trackLow     <= 8'h00;
            trackHigh    <= 8'h00;
            sdhReg       <= 8'h00;
            cmdStrobe    <= 1'b0;
            cmdCode      <= 8'h00;
            dmaAddr      <= 24'h00_0000;
            eccSyndrome  <= 32'h0000_0000;
        end else begin
            cmdStrobe <= 1'b0;

            if (rdAcc) begin
                dataOut <= rdData;
            end
            if (wrAcc && offset == `DCHP_OFS_CMDSTAT) begin
                bufPtr_reg <= {BUF_AW{1'b0}};
            end else if (hostBufAcc || dmaBufWr || fifoPush) begin
                bufPtr_reg <= bufPtr_reg + 1'b1;
            end
            if (hostBufAcc || dmaBufWr || fifoPush) begin
                // Running syndrome over every byte crossing the buffer port.
                eccSyndrome <= {eccSyndrome[23:0], eccSyndrome[31:24] ^
                    (dmaBufWr ? dmaDataIn : (wrAcc ? dataIn : buffer[bufPtr_reg]))};
            end else if (wrAcc && offset == `DCHP_OFS_CMDSTAT) begin
                eccSyndrome <= 32'h0000_0000;
            end

            if (diagDone) begin
                errorReg_reg <= diagCode;
                diagMode_reg <= 1'b1;
            end else if (driveErrorValid) begin
                errorReg_reg <= driveError;
                diagMode_reg <= 1'b0;
            end

            if (wrAcc) begin
                case (offset)
                    `DCHP_OFS_ERROR:   precompCyl   <= dataIn;
                    `DCHP_OFS_COUNT:   sectorCount  <= dataIn;
                    `DCHP_OFS_SECTOR:  sectorNumber <= dataIn;
                    `DCHP_OFS_TRKLO:   trackLow     <= dataIn;
                    `DCHP_OFS_TRKHI:   trackHigh    <= dataIn;
                    `DCHP_OFS_SDH:     sdhReg       <= dataIn;
                    `DCHP_OFS_CMDSTAT: begin
                        cmdStrobe <= 1'b1;
                        cmdCode   <= dataIn;
                    end
                    `DCHP_OFS_DMALO:   dmaAddr[7:0]   <= dataIn;
                    `DCHP_OFS_DMAMID:  dmaAddr[15:8]  <= dataIn;
                    `DCHP_OFS_DMAEXT:  dmaAddr[23:16] <= dataIn;
                    `DCHP_OFS_CONTROL: control_reg    <= dataIn;
                    default: ;
                endcase
            end else if ((dmaBufWr || fifoOutReady) && fifoOutValid | dmaBufWr) begin
                dmaAddr <= dmaAddr + 24'h00_0001;
            end
        end
    end

    // Bus mastership only after the arbitration chain grants it.
    always @(posedge clk or posedge intRst) begin
        if (intRst) begin
            dmaState_reg <= D_IDLE;
            dmaLeft_reg  <= 10'd0;
            dmaMemRead   <= 1'b0;
            dmaMemWrite  <= 1'b0;
            dmaDataOut   <= 8'h00;
        end else begin
            case (dmaState_reg)
                D_IDLE: begin
                    if (control_reg[`DCHP_CTL_DMAEN] && cmdStrobe) begin
                        dmaState_reg <= D_ARB;
                        dmaLeft_reg  <= sectorBytes(sdhReg[6:5]);
                    end
                end

                D_ARB: begin
                    if (busGrant && busRequestIn_n) begin
                        dmaState_reg <= D_MOVE;
                    end
                end

                D_MOVE: begin
                    if (control_reg[`DCHP_CTL_DMADIR]) begin
                        if (fifoOutReady) begin
                            // Gap after each ack; the next byte then settles.
                            dmaMemWrite <= 1'b0;
                        end else begin
                            dmaMemWrite <= fifoOutValid;
                            dmaDataOut  <= fifoOutData;
                        end
                        if (fifoPush) begin
                            dmaLeft_reg <= dmaLeft_reg - 10'd1;
                        end
                        if (dmaLeft_reg == 10'd0 && !fifoOutValid && !dmaMemWrite) begin
                            dmaState_reg <= D_IDLE;
                        end
                    end else begin
                        dmaMemRead <= (dmaLeft_reg != 10'd0);
                        if (dmaBufWr) begin
                            dmaLeft_reg <= dmaLeft_reg - 10'd1;
                        end
                        if (dmaLeft_reg == 10'd0) begin
                            dmaMemRead   <= 1'b0;
                            dmaState_reg <= D_IDLE;
                        end
                    end
                end
                default: dmaState_reg <= D_IDLE;
            endcase
        end
    end

    // The request holds from arbitration to the last byte.
    assign busRequestOut_n = !(dmaState_reg == D_ARB || dmaState_reg == D_MOVE);
    assign dmaActive  = (dmaState_reg == D_MOVE);
    assign headSelect = {control_reg[`DCHP_CTL_HEAD3] & headExtendJumper, sdhReg[2:0]};

    assign unitIsFloppy = (sdhReg[4:3] == 2'd3);
    assign hardUnit   = sdhReg[4:3];
    assign floppyUnit = sdhReg[1:0];

    // Only the configured level carries the interrupt.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : gIrq
            assign irqOut[gi] = driveIrq && (irqLevelSelect == gi);
        end
    endgenerate
endmodule // dchp_host_port

// ==== dchp_regs.vh ====
`ifndef DCHP_REGS_VH
`define DCHP_REGS_VH
`define DCHP_OFS_BUFFER    4'h0
`define DCHP_OFS_ERROR     4'h1
`define DCHP_OFS_COUNT     4'h2
`define DCHP_OFS_SECTOR    4'h3
`define DCHP_OFS_TRKLO     4'h4
`define DCHP_OFS_TRKHI     4'h5
`define DCHP_OFS_SDH       4'h6
`define DCHP_OFS_CMDSTAT   4'h7
`define DCHP_OFS_DMALO     4'h8
`define DCHP_OFS_DMAMID    4'h9
`define DCHP_OFS_DMAEXT    4'hA
`define DCHP_OFS_CONTROL   4'hB
`define DCHP_CTL_DMAEN     0
`define DCHP_CTL_DMADIR    1
`define DCHP_CTL_HEAD3     2
`define DCHP_ERR_NODAM     0
`define DCHP_ERR_TRK0      1
`define DCHP_ERR_ABORT     2
`define DCHP_ERR_IDNF      4
`define DCHP_ERR_UNCORR    6
`define DCHP_ERR_BADBLK    7
`define DCHP_ST_ERROR      0
`define DCHP_ST_BUSY       7
`define DCHP_DIAG_PASS     8'h00
`define DCHP_DIAG_FLOPPY   8'h01
`define DCHP_DIAG_HARD     8'h02
`define DCHP_DIAG_BUFFER   8'h03
`define DCHP_DIAG_SUPPORT  8'h04
`define DCHP_DIAG_CPU      8'h05
`define DCHP_CMD_TEST      8'h90
`define DCHP_WAIT_STATES   2
`define DCHP_BUF_DEPTH     1024
`endif

// ==== dchp_fifo.v ====
`timescale 1ns/1ps
module dchp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output reg  [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_reg;
    reg [AW-1:0]    rdPtr_reg;
    reg [AW:0]      count_reg;
    reg             outValid_reg;
    wire            push = inValid && inReady;
    wire            pop  = (!outValid_reg || outReady) && (count_reg != {(AW+1){1'b0}});
    assign inReady  = (count_reg != DEPTH[AW:0]);
    assign outValid = outValid_reg;
    always @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg    <= {AW{1'b0}};
            rdPtr_reg    <= {AW{1'b0}};
            count_reg    <= {(AW+1){1'b0}};
            outValid_reg <= 1'b0;
            outData      <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg    <= rdPtr_reg + 1'b1;
                outData      <= mem[rdPtr_reg];
                outValid_reg <= 1'b1;
            end else if (outReady) begin
                outValid_reg <= 1'b0;
            end
            count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // dchp_fifo

// ==== dchp_mem_model.sv ====
`timescale 1ns/1ps
// Host memory and arbiter seen from the board; data lines toggle when not acknowledged.
module dchp_mem_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        busRequestOut_n,
    input  wire logic        busRequestIn_n,
    input  wire logic        dmaMemRead,
    input  wire logic        dmaMemWrite,
    input  wire logic [23:0] dmaAddr,
    output logic             busGrant,
    output logic             dmaAck,
    output logic [7:0]       dmaDataIn,
    output int               ackCount
);
    logic [1:0] gap;
    logic       slow;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busGrant <= 1'h0;
            dmaAck <= 1'h0;
            dmaDataIn <= 8'h00;
            gap <= 2'h0;
            slow <= 1'h0;
            ackCount <= 0;
        end else begin
            // A higher-priority request withholds the grant.
            busGrant <= !busRequestOut_n && busRequestIn_n;
            dmaAck <= 1'h0;
            dmaDataIn <= ~dmaDataIn;
            if (gap != 2'h0) begin
                gap <= gap - 2'h1;
            end else if (busGrant && (dmaMemRead || dmaMemWrite) && !dmaAck) begin
                dmaAck <= 1'h1;
                dmaDataIn <= dmaAddr[7:0] ^ 8'h5A;
                // Alternate quick and slow answers.
                gap <= slow ? 2'h3 : 2'h1;
                slow <= !slow;
                ackCount <= ackCount + 1;
            end
        end
    end
endmodule // dchp_mem_model

// ==== dchp_host_port_chk.sv ====
`timescale 1ns/1ps
module dchp_host_port_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  baseAddressSwitch,
    input wire logic        twoWaitJumper,
    input wire logic [2:0]  irqLevelSelect,
    input wire logic [7:0]  ioAddr,
    input wire logic        ioRead,
    input wire logic        ioWrite,
    input wire logic [7:0]  dataIn,
    input wire logic [7:0]  dataOut,
    input wire logic        dataOutEn_n,
    input wire logic        waitReq,
    input wire logic        ioDone,
    input wire logic [7:0]  irqOut,
    input wire logic        driveIrq,
    input wire logic        cmdStrobe,
    input wire logic [7:0]  cmdCode,
    input wire logic [7:0]  sectorCount,
    input wire logic [7:0]  sectorNumber,
    input wire logic        busGrant,
    input wire logic [23:0] dmaAddr,
    input wire logic        dmaMemRead,
    input wire logic        dmaMemWrite,
    input wire logic        dmaAck
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire sel = ioAddr[7:4] == baseAddressSwitch;
    wire stb = ioRead || ioWrite;

    a_base_match: assert property (!sel |-> !ioDone && dataOutEn_n)
        else $error("foreign address answered");
    a_high_undriven: assert property (ioRead && ioAddr[3] |-> dataOutEn_n)
        else $error("high offset read drove bus");
    a_low_driven: assert property (ioRead && sel && !ioAddr[3] |-> !dataOutEn_n)
        else $error("low offset read not driven");
    a_two_waits: assert property (twoWaitJumper && sel && $rose(stb) |->
        waitReq && !ioDone ##1 waitReq && !ioDone ##1 ioDone) else $error("wait count wrong");
    a_no_wait: assert property (!twoWaitJumper && sel && $rose(stb) |-> ioDone && !waitReq)
        else $error("access delayed without jumper");
    a_cmd_issue: assert property (ioDone && ioWrite && ioAddr[3:0] == 4'h7 |=>
        cmdStrobe && cmdCode == $past(dataIn)) else $error("command not issued");
    a_param_store: assert property (ioDone && ioWrite && ioAddr[3:0] == 4'h2 |=>
        sectorCount == $past(dataIn)) else $error("count not stored");
    a_param_read: assert property (ioDone && ioRead && ioAddr[3:0] == 4'h3 |=>
        dataOut == sectorNumber) else $error("sector readback wrong");
    a_irq_route: assert property (irqOut == ({7'h00, driveIrq} << irqLevelSelect))
        else $error("interrupt on wrong line");
    a_master_grant: assert property (dmaMemRead || dmaMemWrite |-> busGrant)
        else $error("bus driven without grant");
    a_dma_step: assert property (dmaAck && (dmaMemRead || dmaMemWrite) |=>
        dmaAddr == $past(dmaAddr) + 24'h00_0001) else $error("address not stepped");
endmodule // dchp_host_port_chk

bind dchp_host_port dchp_host_port_chk u_chk (
    .clk, .rst, .baseAddressSwitch, .twoWaitJumper, .irqLevelSelect, .ioAddr, .ioRead,
    .ioWrite, .dataIn, .dataOut, .dataOutEn_n, .waitReq, .ioDone, .irqOut, .driveIrq,
    .cmdStrobe, .cmdCode, .sectorCount, .sectorNumber, .busGrant, .dmaAddr, .dmaMemRead,
    .dmaMemWrite, .dmaAck);

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    logic        clk, rst, busResetA, busResetB, resetSelect, twoWaitJumper, rden;
    logic        headExtendJumper, ioRead, ioWrite, driveIrq, driveErrorValid, diagDone;
    logic        dataOutEn_n, waitReq, ioDone, cmdStrobe, busRequestOut_n, busGrant;
    logic        busRequestIn_n, dmaMemRead, dmaMemWrite, dmaAck, dmaActive;
    logic [2:0]  irqLevelSelect;
    logic [3:0]  baseAddressSwitch, headSelect;
    logic [7:0]  ioAddr, dataIn, driveStatus, driveError, diagCode, rdq, dataOut, irqOut;
    logic [7:0]  cmdCode, precompCyl, sectorCount, sectorNumber, trackLow, trackHigh;
    logic [7:0]  sdhReg, diskRdData, dmaDataOut, dmaDataIn;
    logic [9:0]  diskAddr;
    logic [23:0] dmaAddr;
    int          fail_count, tests_run, waits, ackCount;

    dchp_host_port dut (
        .clk, .rst, .busResetA, .busResetB, .resetSelect, .baseAddressSwitch,
        .twoWaitJumper, .headExtendJumper, .irqLevelSelect, .ioAddr, .ioRead, .ioWrite,
        .dataIn, .dataOut, .dataOutEn_n, .waitReq, .ioDone, .irqOut, .driveIrq,
        .driveStatus, .driveError, .driveErrorValid, .diagCode, .diagDone, .cmdStrobe,
        .cmdCode, .headSelect, .hardUnit(), .floppyUnit(), .unitIsFloppy(), .precompCyl,
        .sectorCount, .sectorNumber, .trackLow, .trackHigh, .sdhReg, .diskWrEn(1'h0),
        .diskAddr, .diskWrData(8'h00), .diskRdData, .eccSyndrome(), .busRequestIn_n,
        .busRequestOut_n, .busGrant, .dmaAddr, .dmaDataOut, .dmaDataIn, .dmaMemRead,
        .dmaMemWrite, .dmaAck, .dmaActive);

    dchp_mem_model mem (
        .clk, .rst, .busRequestOut_n, .busRequestIn_n, .dmaMemRead, .dmaMemWrite,
        .dmaAddr, .busGrant, .dmaAck, .dmaDataIn, .ackCount);

    task chk(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the strobe until taken or six waits pass, then leaves it low for two cycles.
    task acc(input w, input [3:0] o, input [7:0] d);
        @(posedge clk);
        ioAddr <= {4'h5, o};
        ioWrite <= w;
        ioRead <= !w;
        dataIn <= d;
        @(negedge clk);
        rden = dataOutEn_n;
        waits = 0;
        while (!ioDone && waits < 6) begin
            @(negedge clk);
            waits++;
        end
        @(posedge clk);
        ioRead <= 1'h0;
        ioWrite <= 1'h0;
        @(negedge clk);
        rdq = dataOut;
        @(posedge clk);
    endtask

    task stop_test;
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task t_regs;
        for (int a = 2; a < 7; a++) begin
            acc(1, a[3:0], 8'hA0 + a[7:0]);
            acc(0, a[3:0], 8'h00);
            chk(rdq, 8'hA0 + a);
            chk(rden, 0);
        end
        chk(sectorCount, 8'hA2);
        acc(1, 4'h1, 8'h3C);
        chk(precompCyl, 8'h3C);
        acc(0, 4'h1, 8'h00);
        chk(rdq, 8'h00);
    endtask

    task t_decode;
        for (int a = 8; a < 16; a++) begin
            acc(0, a[3:0], 8'h00);
            chk(rden, 1);
            chk(waits, 0);
        end
        baseAddressSwitch <= 4'h3;
        acc(0, 4'h2, 8'h00);
        chk(waits, 6);
        chk(rden, 1);
        baseAddressSwitch <= 4'h5;
    endtask

    task t_wait;
        twoWaitJumper <= 1'h1;
        acc(0, 4'h2, 8'h00);
        chk(waits, 2);
        acc(1, 4'hC, 8'h11);
        chk(waits, 2);
        twoWaitJumper <= 1'h0;
    endtask

    // A whole 128-byte sector, since partial blocks are not allowed.
    task t_buffer;
        acc(1, 4'h6, 8'h60);
        acc(1, 4'h7, 8'h20);
        for (int i = 0; i < 128; i++)
            acc(1, 4'h0, i[7:0] ^ 8'h3C);
        acc(1, 4'h7, 8'h20);
        for (int i = 0; i < 128; i++) begin
            acc(0, 4'h0, 8'h00);
            chk(rdq, i[7:0] ^ 8'h3C);
        end
    endtask

    task t_irq;
        driveIrq <= 1'h1;
        for (int l = 0; l < 8; l++) begin
            @(posedge clk);
            irqLevelSelect <= l[2:0];
            @(negedge clk);
            chk(irqOut, 8'h01 << l);
        end
        @(posedge clk);
        driveIrq <= 1'h0;
    endtask

    task t_head;
        headExtendJumper <= 1'h1;
        acc(1, 4'h6, 8'h07);
        acc(1, 4'hB, 8'h04);
        chk(headSelect, 4'hF);
        headExtendJumper <= 1'h0;
        @(negedge clk);
        chk(headSelect, 4'h7);
        @(posedge clk);
    endtask

    task t_diag;
        driveStatus <= 8'h81;
        for (int c = 0; c < 6; c++) begin
            @(posedge clk);
            diagCode <= c[7:0];
            diagDone <= 1'h1;
            @(posedge clk);
            diagDone <= 1'h0;
            acc(0, 4'h1, 8'h00);
            chk(rdq, c);
            acc(0, 4'h7, 8'h00);
            chk(rdq, 8'h80);
        end
        @(posedge clk);
        driveError <= 8'hD7;
        driveErrorValid <= 1'h1;
        @(posedge clk);
        driveErrorValid <= 1'h0;
        acc(0, 4'h1, 8'h00);
        chk(rdq, 8'hD7);
        acc(0, 4'h7, 8'h00);
        chk(rdq, 8'h81);
    endtask

    task t_reset;
        resetSelect <= 1'h1;
        acc(1, 4'h2, 8'h77);
        busResetA <= 1'h1;
        @(posedge clk);
        busResetA <= 1'h0;
        acc(0, 4'h2, 8'h00);
        chk(rdq, 8'h77);
        busResetB <= 1'h1;
        @(posedge clk);
        busResetB <= 1'h0;
        @(negedge clk);
        chk(sectorCount, 8'h00);
        @(posedge clk);
        resetSelect <= 1'h0;
    endtask

    task t_dma;
        acc(1, 4'h8, 8'h12);
        acc(1, 4'h9, 8'h34);
        acc(1, 4'hA, 8'h56);
        acc(1, 4'h6, 8'h60);
        acc(1, 4'hB, 8'h01);
        busRequestIn_n <= 1'h0;
        acc(1, 4'h7, 8'h20);
        repeat (20) @(negedge clk);
        chk(dmaMemRead, 0);
        @(posedge clk);
        busRequestIn_n <= 1'h1;
        for (int i = 0; i < 3000 && (i < 5 || dmaActive); i++)
            @(negedge clk);
        chk(ackCount, 128);
        chk(dmaAddr, 24'h56_3492);
        @(posedge clk);
        diskAddr <= 10'h005;
        @(posedge clk);
        @(negedge clk);
        chk(diskRdData, 8'h17 ^ 8'h5A);
    endtask

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Far beyond the roughly 1400 cycles the sequence needs.
    initial begin
        #400000;
        fail_count++;
        stop_test();
    end

    initial begin
        {rst, busRequestIn_n} = 2'h3;
        {busResetA, busResetB, resetSelect, twoWaitJumper, headExtendJumper} = 5'h00;
        {ioRead, ioWrite, driveIrq, driveErrorValid, diagDone} = 5'h00;
        {irqLevelSelect, baseAddressSwitch} = {3'h0, 4'h5};
        {ioAddr, dataIn, driveStatus, driveError, diagCode} = 40'h00_0000_0000;
        diskAddr = 10'h000;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        t_regs();
        t_decode();
        t_wait();
        t_buffer();
        t_irq();
        t_head();
        t_diag();
        t_reset();
        t_dma();
        stop_test();
    end
endmodule // tb
